// file: cell_storage.sv
// Purpose: Bit array of the cell pair with two write ports and a shift path
// Assumes: Write and shift strobes are qualified by the controller with the active cell edge
// Notes:   Reads are the raw array; the controller selects bits combinationally
`timescale 1ns/10ps
`default_nettype none
module cell_storage
  import logic_cell_pkg::*;
#(
  parameter int DEPTH = 32
)(
  input wire logic    clk,
  input wire logic    rst_b,
  cell_store_if.store st
);

  // Array must hold at least the shift stages and a full sixteen-word block
  if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("cell_storage: DEPTH must be a power of two, at least 16");
  end

  typedef struct packed {
    logic [DEPTH-1:0] bits;
  } store_state_t;

  store_state_t cur;   // Registered state
  store_state_t nxt;   // Next state

  //////////////////////////////////////////////////////////////////////////////
  // Next state: init load beats shifting, port A is applied last so it wins
  always_comb begin
    nxt = cur;
    if (st.initLoad) begin
      nxt.bits = st.initImage;
    end else if (st.shift) begin
      // Word 0 takes the serial bit, each of the low seven words moves one place up
      nxt.bits[SHIFT_MSB:0] = {cur.bits[SHIFT_MSB-1:0], st.shiftIn};
    end else begin
      if (st.wrB) begin
        nxt.bits[st.addrB] = st.dataB;
      end
      if (st.wrA) begin
        nxt.bits[st.addrA] = st.dataA;
      end
    end
  end

  // Register the array
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign st.contents = cur.bits;

endmodule
`default_nettype wire

// file: cell_store_if.sv
// Purpose: Carrier between the cell controller and its bit storage
// Assumes: One clock; all requests are single-cycle strobes
// Notes:   DEPTH sets the number of one-bit words
`timescale 1ns/10ps
`default_nettype none
interface cell_store_if #(
  parameter int DEPTH = 32
);
  localparam int AW = $clog2(DEPTH);

  logic             initLoad;   // Replace whole image
  logic [DEPTH-1:0] initImage;  // Image to load
  logic             wrA;        // Port A write strobe
  logic [AW-1:0]    addrA;      // Port A address
  logic             dataA;      // Port A data
  logic             wrB;        // Port B write strobe
  logic [AW-1:0]    addrB;      // Port B address
  logic             dataB;      // Port B data
  logic             shift;      // Shift strobe, low eight words
  logic             shiftIn;    // Bit entering word 0
  logic [DEPTH-1:0] contents;   // Current stored bits

  modport ctrl (output initLoad, initImage, wrA, addrA, dataA, wrB, addrB, dataB,
                output shift, shiftIn, input contents);
  modport store (input initLoad, initImage, wrA, addrA, dataA, wrB, addrB, dataB,
                 input shift, shiftIn, output contents);
endinterface
`default_nettype wire

// file: fabric_user.sv
// Purpose: Fabric logic driving the cell-side inputs of the pair
// Assumes: The cell clock stands still between steps
// Notes:   Inputs are set up a cycle before each cell clock edge
`timescale 1ns/10ps
`default_nettype none
module fabric_user (
  input  wire logic   clk,
  output logic        cellClk,
  output logic [20:0] stim
);
  // Idle: clock low, every request off
  initial begin
    cellClk = 1'b0;
    stim = 21'h0_0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One cell clock edge with fresh inputs; gap stalls the fabric afterwards
  task automatic step(input logic lvl, input int gap);
    logic [31:0] r;
    r = $urandom;
    if (r[31]) r[10:7] = r[3:0];    // Aim port B at port A to provoke contention
    r[19] = r[19] & r[29];          // Keep preload rare
    r[20] = r[20] & r[30] & r[28];  // Upstream chain error rarer still
    @(posedge clk);
    stim <= r[20:0];
    @(posedge clk);
    cellClk <= lvl;
    repeat (3 + gap) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: logic_cell.sv
// Purpose: Memory and sequential modes of one logic cell or a cell pair
// Assumes: Cell inputs are synchronous to clk; cellClk is sampled, not a clock
// Notes:   Software fills contents and control while stopped, then sets run
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Four or five address bits select words
// - RAM writes on active edge when enabled
// - Write edge polarity chosen by configuration
// - RAM read follows address without clock
// - Contents loaded during initialization phase
// - Two ports, sixteen words, shared clock
// - Same-address differing writes flag chained error
// - ROM output follows four or five address bits
// - ROM contents never change while running
// - Eight stages, serial in, serial out
// - Shift/load low writes addressed stage only
// - Shift/load high shifts toward stage seven
// - Serial output is stage seven
// - Tap output shows addressed stage
// - Enable low holds all eight stages
// - Flip-flop captures only with enable high
// - Flip-flop edge polarity selectable
// - Preload high forces preload value immediately
// - Unused preload tied low, synchronous operation
// - Initial value held against writes during init
module logic_cell
  import logic_cell_pkg::*;
#(
  parameter int DEPTH = 32
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Cell clock and memory ports
  input  wire logic        cellClk,
  input  wire logic [4:0]  address,
  input  wire logic        dataIn,
  input  wire logic        writeEnable,
  input  wire logic [3:0]  addressB,
  input  wire logic        dataInB,
  input  wire logic        writeEnableB,
  output logic             dataOut,
  output logic             dataOutB,
  input  wire logic        errorChainIn,
  output logic             errorChainOut,
  // Shifter
  input  wire logic        shift_not_load,
  input  wire logic        serial_in,
  input  wire logic        parallel_in,
  input  wire logic        shiftEnable,
  output logic             serial_out,
  // Flip-flop
  input  wire logic        ffD,
  input  wire logic        ffClockEnable,
  input  wire logic        preload_in,
  output logic             ffQ
);

  // The five-bit address and the shifter need exactly this array size
  if (DEPTH != 32) begin : g_bad_depth
    $error("logic_cell: DEPTH must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    phase_t      phase;       // Init or running
    cell_mode_t  mode;        // Operating mode
    logic        ramInvert;   // RAM/shifter writes on falling cellClk
    logic        ffInvert;    // Flip-flop on falling cellClk
    logic        init_value;  // Flip-flop value during init
    logic        preload_value; // Flip-flop value under preload
    logic        prevClk;     // cellClk one cycle ago
    logic        ffState;     // Flip-flop storage
    logic        collision;   // Sticky write contention
    logic        awPend;      // Write address held
    logic [7:0]  awAddr;
    logic        wPend;       // Write data held
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cell_state_t;

  cell_state_t cur;  // Registered state
  cell_state_t nxt;  // Next state

  cell_store_if #(.DEPTH(DEPTH)) st ();

  logic        rise;       // cellClk rising seen this cycle
  logic        fall;       // cellClk falling seen this cycle
  logic        ramEdge;    // Active edge for memory and shifter
  logic        ffEdge;     // Active edge for the flip-flop
  logic        running;    // Not in initialization
  logic [31:0] ctrlWord;   // Control register as read
  logic [31:0] statWord;   // Status register as read
  logic [31:0] merged;     // Byte-merged write value
  logic [31:0] oldWord;    // Word being written, before merge
  logic        doWrite;    // Register write performed this cycle
  logic        contend;    // Contention seen at this edge

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection on the sampled cell clock
  // No synchroniser: cell inputs come from the same clock domain
  assign rise    = cellClk & ~cur.prevClk;
  assign fall    = ~cellClk & cur.prevClk;
  assign ramEdge = cur.ramInvert ? fall : rise;
  assign ffEdge  = cur.ffInvert ? fall : rise;
  assign running = (cur.phase == PH_RUN);

  // Register images for reads and merges
  always_comb begin
    ctrlWord = '0;
    ctrlWord[CTRL_RUN_BIT] = running;
    ctrlWord[CTRL_MODE_LSB +: 3] = cur.mode;
    ctrlWord[CTRL_RAM_INV_BIT] = cur.ramInvert;
    ctrlWord[CTRL_FF_INV_BIT] = cur.ffInvert;
    ctrlWord[CTRL_INIT_VAL_BIT] = cur.init_value;
    ctrlWord[CTRL_PRELOAD_BIT] = cur.preload_value;
    statWord = '0;
    statWord[STAT_COLLIDE_BIT] = cur.collision;
    statWord[STAT_RUN_BIT] = running;
    statWord[STAT_FFQ_BIT] = ffQ;
  end

  // Byte-lane merge of the pending write
  always_comb begin
    case (cur.awAddr)
      OFS_CTRL: oldWord = ctrlWord;
      OFS_CONTENTS: oldWord = st.contents;
      default: oldWord = '0;
    endcase
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = cur.wStrb[i] ? cur.wData[i*8 +: 8] : oldWord[i*8 +: 8];
    end
  end

  assign doWrite = cur.awPend & cur.wPend & ~cur.bvalid;

  // Contention: both ports write one word with differing data
  assign contend = running && (cur.mode == MODE_DUAL) && ramEdge && writeEnable && writeEnableB &&
                   (address[3:0] == addressB) && (dataIn != dataInB);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage requests
  always_comb begin
    st.initLoad  = 1'b0;
    st.initImage = merged;
    st.wrA       = 1'b0;
    st.addrA     = address;
    st.dataA     = dataIn;
    st.wrB       = 1'b0;
    st.addrB     = {1'b0, addressB};
    st.dataB     = dataInB;
    st.shift     = 1'b0;
    st.shiftIn   = serial_in;
    // Image loads only while stopped, so ROM stays fixed in operation
    if (doWrite && cur.awAddr == OFS_CONTENTS && !running) begin
      st.initLoad = 1'b1;
    end
    if (running && ramEdge) begin
      case (cur.mode)
        MODE_RAM16: begin
          st.wrA   = writeEnable;
          st.addrA = {1'b0, address[3:0]};
        end
        MODE_RAM32: begin
          st.wrA = writeEnable;
        end
        MODE_DUAL: begin
          // Port A wins a contended word; the error flag reports it
          st.wrA   = writeEnable;
          st.addrA = {1'b0, address[3:0]};
          st.wrB   = writeEnableB;
        end
        MODE_SHIFT: begin
          if (shiftEnable) begin
            if (shift_not_load) begin
              st.shift = 1'b1;
            end else begin
              st.wrA   = 1'b1;
              st.addrA = {2'b00, address[2:0]};
              st.dataA = parallel_in;
            end
          end
        end
        default: begin
          // ROM modes never write
          st.wrA = 1'b0;
        end
      endcase
    end
  end

  cell_storage #(.DEPTH(DEPTH)) u_storage (
    .clk   (clk),
    .rst_b (rst_b),
    .st    (st.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational read paths
  always_comb begin
    case (cur.mode)
      MODE_RAM32, MODE_ROM32: dataOut = st.contents[address];
      MODE_SHIFT: dataOut = st.contents[{2'b00, address[2:0]}];
      default: dataOut = st.contents[{1'b0, address[3:0]}];
    endcase
  end

  assign dataOutB      = st.contents[{1'b0, addressB}];
  assign serial_out    = st.contents[SHIFT_MSB];
  assign errorChainOut = errorChainIn | cur.collision;
  // Preload shows at once, without waiting for an edge
  assign ffQ = (running && preload_in) ? cur.preload_value : cur.ffState;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: configuration, flip-flop, contention flag, bus slave
  always_comb begin
    nxt = cur;
    nxt.prevClk = cellClk;

    // Flip-flop: init value first, then preload, then enabled edge
    if (!running) begin
      nxt.ffState = cur.init_value;
    end else if (preload_in) begin
      nxt.ffState = cur.preload_value;
    end else if (ffEdge && ffClockEnable) begin
      nxt.ffState = ffD;
    end

    // Bus handshakes
    if (awvalid && !cur.awPend) begin
      nxt.awPend = 1'b1;
      nxt.awAddr = awaddr;
    end
    if (wvalid && !cur.wPend) begin
      nxt.wPend = 1'b1;
      nxt.wData = wdata;
      nxt.wStrb = wstrb;
    end
    if (cur.bvalid && bready) begin
      nxt.bvalid = 1'b0;
    end

    // Register write once address and data are both held
    if (doWrite) begin
      nxt.awPend = 1'b0;
      nxt.wPend  = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp  = RESP_OKAY;
      case (cur.awAddr)
        OFS_CTRL: begin
          nxt.phase         = merged[CTRL_RUN_BIT] ? PH_RUN : PH_INIT;
          nxt.mode          = cell_mode_t'(merged[CTRL_MODE_LSB +: 3]);
          nxt.ramInvert     = merged[CTRL_RAM_INV_BIT];
          nxt.ffInvert      = merged[CTRL_FF_INV_BIT];
          nxt.init_value    = merged[CTRL_INIT_VAL_BIT];
          nxt.preload_value = merged[CTRL_PRELOAD_BIT];
        end
        OFS_CONTENTS: begin
          // Loaded by the storage strobe; ignored while running
          nxt.bresp = RESP_OKAY;
        end
        OFS_STATUS: begin
          if (cur.wStrb[0] && cur.wData[STAT_COLLIDE_BIT]) begin
            nxt.collision = 1'b0;
          end
        end
        default: begin
          nxt.bresp = RESP_SLVERR;
        end
      endcase
    end

    // A new contention beats a clear in the same cycle
    if (contend) begin
      nxt.collision = 1'b1;
    end

    // Read channel: one read in flight, answer on the next cycle
    if (cur.rvalid && rready) begin
      nxt.rvalid = 1'b0;
    end
    if (arvalid && !cur.rvalid) begin
      nxt.rvalid = 1'b1;
      nxt.rresp  = RESP_OKAY;
      case (araddr)
        OFS_CTRL: nxt.rdata = ctrlWord;
        OFS_CONTENTS: nxt.rdata = st.contents;
        OFS_STATUS: nxt.rdata = statWord;
        default: begin
          nxt.rdata = '0;
          nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign awready = ~cur.awPend;
  assign wready  = ~cur.wPend;
  assign bvalid  = cur.bvalid;
  assign bresp   = cur.bresp;
  assign arready = ~cur.rvalid;
  assign rvalid  = cur.rvalid;
  assign rdata   = cur.rdata;
  assign rresp   = cur.rresp;

endmodule
`default_nettype wire

// file: logic_cell_assertions.sv
// Purpose: Port-level assertions for the logic cell pair
// Assumes: Control writes use all four byte strobes
// Notes:   Snoops AXI writes to mirror the control byte
`timescale 1ns/10ps
`default_nettype none
module logic_cell_assertions
  import logic_cell_pkg::*;
#(
  parameter int DEPTH = 32
)(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        cellClk,
  input wire logic [4:0]  address,
  input wire logic        writeEnable,
  input wire logic        shiftEnable,
  input wire logic        preload_in,
  input wire logic        errorChainIn,
  input wire logic        errorChainOut,
  input wire logic        dataOut,
  input wire logic        serial_out,
  input wire logic        ffQ
);
  ////////////////////////////////////////////////////////////////////////////////
  // Snoop state: taken address, taken data byte, control mirror, last bvalid
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] ctl;
    logic       bPrev;
  } snoop_t;
  snoop_t sn;       // Registered snoop
  snoop_t next_sn;  // Next snoop
  logic   quiet;    // Mirror is current: no response now or last cycle
  // Mirror lags the design by a cycle, so checks wait for the quiet window
  always_comb begin
    next_sn = sn;
    next_sn.bPrev = bvalid;
    if (awvalid && awready) next_sn.addr = awaddr;
    if (wvalid && wready) next_sn.data = wdata[7:0];
    if (bvalid && !sn.bPrev && bresp == RESP_OKAY && sn.addr == OFS_CTRL) next_sn.ctl = sn.data;
  end
  // Snoop register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sn <= '0;
    else sn <= next_sn;
  end
  assign quiet = !bvalid && !sn.bPrev;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  a_chain_or:
    assert property (errorChainIn |-> errorChainOut) else $error("Upstream error not passed on");
  a_preload_wins:
    assert property (sn.ctl[0] && preload_in && quiet |-> ffQ == sn.ctl[7]) else $error("Preload did not force ffQ");
  a_init_value:
    assert property (!sn.ctl[0] && quiet |-> ffQ == sn.ctl[6]) else $error("ffQ left its initial value");
  a_ff_hold:
    assert property (quiet && !preload_in && !$past(preload_in) && $past(cellClk) == $past(cellClk, 2)
      |-> $stable(ffQ)) else $error("ffQ moved without a cell edge");
  a_serial_tap:
    assert property (sn.ctl[0] && sn.ctl[3:1] == MODE_SHIFT && address[2:0] == 3'h7 && quiet
      |-> dataOut == serial_out) else $error("Tap seven differs from serial output");
  a_shift_hold:
    assert property (sn.ctl[0] && sn.ctl[3:1] == MODE_SHIFT && !$past(shiftEnable) && quiet
      |-> $stable(serial_out)) else $error("Shifter moved while disabled");
  a_rom_fixed:
    assert property (sn.ctl[0] && (sn.ctl[3:1] == MODE_ROM16 || sn.ctl[3:1] == MODE_ROM32) && quiet
      && $stable(address) |-> $stable(dataOut)) else $error("Read-only word changed");
  a_ram_hold:
    assert property (sn.ctl[0] && sn.ctl[3:1] == MODE_RAM16 && !$past(writeEnable) && quiet
      && $stable(address) |-> $stable(dataOut)) else $error("RAM word changed without write enable");
  a_read_lat:
    assert property (arvalid && arready |=> rvalid) else $error("Read answer late");
endmodule

// Attach the checker to every instance of the cell pair
bind logic_cell logic_cell_assertions #(.DEPTH(DEPTH)) u_checks (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .cellClk(cellClk), .address(address),
  .writeEnable(writeEnable), .shiftEnable(shiftEnable), .preload_in(preload_in), .errorChainIn(errorChainIn),
  .errorChainOut(errorChainOut), .dataOut(dataOut), .serial_out(serial_out), .ffQ(ffQ));
`default_nettype wire

// file: logic_cell_pkg.sv
// Purpose: Shared constants and types for the configurable logic cell model
// Assumes: AXI4-Lite register slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses; all bit positions are named here
package logic_cell_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CONTENTS = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;

  // Control register fields
  localparam int CTRL_RUN_BIT       = 0;
  localparam int CTRL_MODE_LSB      = 1;
  localparam int CTRL_RAM_INV_BIT   = 4;
  localparam int CTRL_FF_INV_BIT    = 5;
  localparam int CTRL_INIT_VAL_BIT  = 6;
  localparam int CTRL_PRELOAD_BIT   = 7;

  // Status register fields
  localparam int STAT_COLLIDE_BIT   = 0;
  localparam int STAT_RUN_BIT       = 1;
  localparam int STAT_FFQ_BIT       = 2;

  // Reset values
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [31:0] CONTENTS_RESET = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Shift register geometry
  localparam int SHIFT_DEPTH = 8;
  localparam int SHIFT_MSB   = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Operating modes of the cell pair
  typedef enum logic [2:0] {
    MODE_RAM16  = 3'h0,
    MODE_RAM32  = 3'h1,
    MODE_DUAL   = 3'h3,
    MODE_ROM16  = 3'h2,
    MODE_ROM32  = 3'h6,
    MODE_SHIFT  = 3'h7
  } cell_mode_t;

  // Initialization phase versus normal operation
  typedef enum logic {
    PH_INIT = 1'b0,
    PH_RUN  = 1'b1
  } phase_t;

endpackage

// file: tb_top.sv
// Purpose: Self-checking bench for the logic cell pair
// Assumes: Cell inputs come from the fabric model, registers over AXI4-Lite
// Notes:   A bit-level model predicts every output after each cell edge
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import logic_cell_pkg::*;
;
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;  // Bench-driven controls
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;               // Slave answers
  logic [1:0]  bresp, rresp;
  logic        cellClk, dataOut, dataOutB, errorChainOut, serial_out, ffQ;
  logic [20:0] stim;        // Fabric inputs bundle
  logic [31:0] mem;         // Model of the stored bits
  logic        ff, col;     // Model flip-flop and sticky collision
  logic [7:0]  ctl;         // Model control byte
  int          mismatches, numChecks;
  cell_mode_t  modes [6] = '{MODE_RAM16, MODE_RAM32, MODE_DUAL, MODE_ROM16, MODE_ROM32, MODE_SHIFT};
  initial clk = 1'b0;
  always #50 clk = ~clk;
  logic_cell #(.DEPTH(32)) dut (
    .clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cellClk(cellClk), .address(stim[4:0]), .dataIn(stim[5]), .writeEnable(stim[6]),
    .addressB(stim[10:7]), .dataInB(stim[11]), .writeEnableB(stim[12]), .dataOut(dataOut),
    .dataOutB(dataOutB), .errorChainIn(stim[20]), .errorChainOut(errorChainOut), .shift_not_load(stim[13]),
    .serial_in(stim[14]), .parallel_in(stim[15]), .shiftEnable(stim[16]), .serial_out(serial_out),
    .ffD(stim[17]), .ffClockEnable(stim[18]), .preload_in(stim[19]), .ffQ(ffQ));
  fabric_user usr (.clk(clk), .cellClk(cellClk), .stim(stim));
  ////////////////////////////////////////////////////////////////////////////////
  // Counts, verdict, end of run
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Write: each channel sampled at the rising edge and released by the edge that takes it
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic tb;
    logic [1:0] rs;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !tb; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        tb = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
    if (!tb) begin
      mismatches++;
      giveVerdict();
    end
    `CHK("bresp", er, rs)
  endtask
  // Read with the same sampling discipline
  task automatic axRead(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic tr;
    logic [31:0] rd;
    logic [1:0] rs;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !tr; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        tr = 1'b1;
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
    if (!tr) begin
      mismatches++;
      giveVerdict();
    end
    `CHK("rresp", er, rs)
    `CHK("rdata", ed, rd)
  endtask
  // One cell edge: advance the model, then compare every cell output
  task automatic cellStep(input logic lvl);
    logic [20:0] s;
    logic [4:0] a;
    logic [2:0] m;
    usr.step(lvl, $urandom % 3);
    s = stim;
    a = s[4:0];
    m = ctl[3:1];
    if (ctl[0] && (lvl ^ ctl[4])) begin  // Active edge of RAM and shifter, polarity per control
      if (m == MODE_RAM16 && s[6]) mem[a[3:0]] = s[5];
      if (m == MODE_RAM32 && s[6]) mem[a] = s[5];
      if (m == MODE_DUAL && s[6] && s[12] && s[10:7] == a[3:0] && s[5] != s[11]) col = 1'b1;
      if (m == MODE_DUAL && s[12]) mem[s[10:7]] = s[11];
      if (m == MODE_DUAL && s[6]) mem[a[3:0]] = s[5];
      if (m == MODE_SHIFT && s[16] && s[13]) mem[7:0] = {mem[6:0], s[14]};
      if (m == MODE_SHIFT && s[16] && !s[13]) mem[a[2:0]] = s[15];
    end
    if (!ctl[0]) ff = ctl[6];
    else if (s[19]) ff = ctl[7];
    else if ((lvl ^ ctl[5]) && s[18]) ff = s[17];
    @(negedge clk);
    `CHK("dataOut", (m == MODE_RAM32 || m == MODE_ROM32) ? mem[a] : (m == MODE_SHIFT ? mem[a[2:0]] : mem[a[3:0]]), dataOut)
    `CHK("dataOutB", mem[s[10:7]], dataOutB)
    `CHK("serial_out", mem[7], serial_out)
    `CHK("errorChainOut", s[20] | col, errorChainOut)
    `CHK("ffQ", ff, ffQ)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset map, then every mode stopped and running
  initial begin
    int i, r;
    logic [31:0] d;
    logic [3:0] st;
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 52'h0_0000_0000_0000;
    {mem, ff, col, ctl} = 42'h000_0000_0000;
    mismatches = 0;
    numChecks = 0;
    r = $urandom(87);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    axRead(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    axRead(OFS_CONTENTS, CONTENTS_RESET, RESP_OKAY);
    axRead(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    axRead(8'h0C, 32'h0000_0000, RESP_SLVERR);
    axWrite(8'h10, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    foreach (modes[k]) begin
      ctl = {3'($urandom), k[0], 3'(modes[k]), 1'b0};  // Both write edge polarities
      axWrite(OFS_CTRL, {24'h00_0000, ctl}, 4'hF, RESP_OKAY);
      ff = ctl[6];
      d = $urandom;
      axWrite(OFS_CONTENTS, d, 4'hF, RESP_OKAY);
      mem = d;
      d = $urandom;
      st = 4'($urandom);
      axWrite(OFS_CONTENTS, d, st, RESP_OKAY);
      for (i = 0; i < 4; i++) if (st[i]) mem[i*8 +: 8] = d[i*8 +: 8];
      axRead(OFS_CONTENTS, mem, RESP_OKAY);
      for (i = 0; i < 4; i++) cellStep(i[0] == 1'b0);
      ctl[0] = 1'b1;
      axWrite(OFS_CTRL, {24'h00_0000, ctl}, 4'hF, RESP_OKAY);
      for (i = 0; i < 40; i++) cellStep(i[0] == 1'b0);
      axWrite(OFS_CONTENTS, ~mem, 4'hF, RESP_OKAY);
      axRead(OFS_CONTENTS, mem, RESP_OKAY);
      axRead(OFS_STATUS, {29'h0000_0000, ff, 1'b1, col}, RESP_OKAY);
      axWrite(OFS_STATUS, 32'h0000_0001, 4'hF, RESP_OKAY);
      col = 1'b0;
    end
    giveVerdict();
  end
endmodule
`default_nettype wire
